// ---- rtl/ctrl_ep_pkg.sv ----
// Shared constants, types and state records of the control endpoint request handler.
package ctrl_ep_pkg;

  // ==========================================================================
  // Setup packet layout
  // ==========================================================================
  localparam int SETUP_BYTES = 8;
  localparam logic [2:0] SETUP_OFS_TYPE = 3'h0;
  localparam logic [2:0] SETUP_OFS_REQ = 3'h1;
  localparam logic [2:0] SETUP_OFS_VALUE_L = 3'h2;
  localparam logic [2:0] SETUP_OFS_VALUE_H = 3'h3;
  localparam logic [2:0] SETUP_OFS_INDEX_L = 3'h4;
  localparam logic [2:0] SETUP_OFS_INDEX_H = 3'h5;
  localparam logic [2:0] SETUP_OFS_LEN_L = 3'h6;
  localparam logic [2:0] SETUP_OFS_LEN_H = 3'h7;
  localparam logic [3:0] SETUP_COUNT_FULL = 4'h8;

  // ==========================================================================
  // Request decoding
  // ==========================================================================
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] REQ_FW_LOAD = 8'hA0;
  localparam logic [7:0] TYPE_STD_DEVICE_OUT = 8'h00;
  localparam logic [7:0] TYPE_VENDOR_MASK = 8'h60;
  localparam logic [7:0] TYPE_VENDOR_MATCH = 8'h40;
  localparam int TYPE_DIR_BIT = 7;

  // ==========================================================================
  // Interrupt enable and request bit positions and reset values
  // ==========================================================================
  localparam int IRQ_BIT_SETUP_DATA = 0;
  localparam int IRQ_BIT_SETUP_TOKEN = 2;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_REQUEST_RESET = 8'h00;
  localparam logic [6:0] FN_ADDR_RESET = 7'h00;

  // ==========================================================================
  // Control IN buffer and bulk endpoints
  // ==========================================================================
  localparam int IN_BUF_DEPTH = 64;
  localparam int BULK_SLOTS = 16;

  typedef enum logic [1:0] {
    HS_ACK = 2'b00,
    HS_NAK = 2'b01,
    HS_STALL = 2'b10,
    HS_DATA = 2'b11
  } hs_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

  // Bytes of the setup data packet as delivered by the serial engine.
  typedef struct packed {
    logic setup_token;
    logic byte_valid;
    logic [7:0] data;
    logic packet_end;
    logic packet_ok;
  } setup_rx_t;

  // Tokens seen on the bus, already decoded by the serial engine.
  typedef struct packed {
    logic in_token;
    logic status_token;
    logic bulk_token;
    logic [3:0] bulk_ep;
    logic bulk_ready;
  } token_t;

  typedef struct packed {
    logic [SETUP_BYTES-1:0][7:0] bytes;
    logic [3:0] count;
    logic bad;
    logic done;
  } store_state_t;

  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] irq_req;
    logic [6:0] fn_addr;
    logic [15:0] sud_ptr;
    logic [IN_BUF_DEPTH-1:0][7:0] in_buf;
    logic [6:0] in_count;
    logic in_armed;
    logic hold;
    logic ep0_stall;
    logic [BULK_SLOTS-1:0] ep_stall;
    tx_state_t tx_state;
    logic [5:0] tx_idx;
    logic [6:0] tx_left;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic hs_valid;
    hs_t hs_code;
    logic load_start;
    logic load_dir;
    logic [15:0] load_addr;
    logic [15:0] load_len;
  } ctrl_state_t;

endpackage

// ---- rtl/setup_byte_store.sv ----
// Eight-byte store for the data packet of a setup transaction.
`timescale 1ns/1ps
`default_nettype none

module setup_byte_store
  import ctrl_ep_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Incoming setup packet
  input wire setup_rx_t rx,
  // Stored bytes and completion
  output logic [SETUP_BYTES-1:0][7:0] setup_byte_area,
  output logic setup_done
);

  store_state_t s_reg;
  store_state_t s_next;

  // ==========================================================================
  // Capture
  // ==========================================================================
  // A packet with a bad check or the wrong length is simply dropped; the host
  // repeats it, and the bytes are overwritten by the retry.
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (rx.setup_token) begin
      s_next.count = 4'h0;
      s_next.bad = 1'b0;
    end
    if (rx.byte_valid) begin
      if (s_reg.count < SETUP_COUNT_FULL) begin
        s_next.bytes[s_reg.count[2:0]] = rx.data;
        s_next.count = s_reg.count + 4'h1;
      end else begin
        s_next.bad = 1'b1;
      end
    end
    if (rx.packet_end) begin
      s_next.done = rx.packet_ok && !s_reg.bad && (s_reg.count == SETUP_COUNT_FULL);
      s_next.count = 4'h0;
      s_next.bad = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign setup_byte_area = s_reg.bytes;
  assign setup_done = s_reg.done;

endmodule // setup_byte_store

`default_nettype wire

// ---- rtl/control_endpoint_request_handler.sv ----
// Endpoint-zero setup handling: interrupt flags, address, stalls and IN replies.
`timescale 1ns/1ps
`default_nettype none

module control_endpoint_request_handler
  import ctrl_ep_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Serial engine side
  input wire setup_rx_t rx,
  input wire token_t tok,
  output logic hs_valid,
  output hs_t hs_code,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  // Firmware control inputs
  input wire logic firmware_in_control,
  input wire logic irq_enable_wr,
  input wire logic [7:0] irq_enable_data,
  input wire logic irq_clear_wr,
  input wire logic [7:0] irq_clear_data,
  input wire logic sud_ptr_high_wr,
  input wire logic sud_ptr_low_wr,
  input wire logic [7:0] sud_ptr_data,
  input wire logic in_buf_wr,
  input wire logic [5:0] in_buf_addr,
  input wire logic [7:0] in_buf_data,
  input wire logic in_count_wr,
  input wire logic [6:0] in_count_data,
  input wire logic hold_clear_wr,
  input wire logic ep0_stall_set,
  input wire logic ep_stall_wr,
  input wire logic [3:0] ep_stall_sel,
  input wire logic ep_stall_val,
  // Status outputs
  output logic [7:0] link_irq_enable_reg,
  output logic [7:0] link_irq_request_reg,
  output logic setup_token_irq_flag,
  output logic setup_data_ready_flag,
  output logic [6:0] function_address_reg,
  output logic [15:0] setup_data_pointer,
  output logic [SETUP_BYTES-1:0][7:0] setup_byte_area,
  output logic status_stage_hold,
  output logic control_endpoint_stall,
  output logic [BULK_SLOTS-1:0] bulk_stall,
  // RAM loader command
  output logic load_start,
  output logic load_dir,
  output logic [15:0] load_addr,
  output logic [15:0] load_len
);

  ctrl_state_t s_reg;
  ctrl_state_t s_next;
  logic setup_done;
  logic [7:0] req_type;
  logic [7:0] req_code;
  logic is_fw_load;
  logic is_set_addr;

  setup_byte_store u_store (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rx(rx),
    .setup_byte_area(setup_byte_area),
    .setup_done(setup_done)
  );

  assign req_type = setup_byte_area[SETUP_OFS_TYPE];
  assign req_code = setup_byte_area[SETUP_OFS_REQ];
  assign is_fw_load = ((req_type & TYPE_VENDOR_MASK) == TYPE_VENDOR_MATCH) &&
                      (req_code == REQ_FW_LOAD);
  assign is_set_addr = (req_type == TYPE_STD_DEVICE_OUT) && (req_code == REQ_SET_ADDRESS);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Firmware writes are applied first and hardware events after them, so an
  // event in the same cycle as a clear always survives.
  always_comb begin
    s_next = s_reg;
    s_next.hs_valid = 1'b0;
    s_next.load_start = 1'b0;
    s_next.tx_valid = 1'b0;

    if (irq_enable_wr) begin
      s_next.irq_en = irq_enable_data;
    end
    if (irq_clear_wr) begin
      s_next.irq_req = s_reg.irq_req & ~irq_clear_data;
    end
    if (sud_ptr_high_wr) begin
      s_next.sud_ptr[15:8] = sud_ptr_data;
    end
    if (sud_ptr_low_wr) begin
      s_next.sud_ptr[7:0] = sud_ptr_data;
    end
    if (in_buf_wr) begin
      s_next.in_buf[in_buf_addr] = in_buf_data;
    end
    if (in_count_wr) begin
      s_next.in_count = in_count_data;
      s_next.in_armed = 1'b1;
    end
    if (hold_clear_wr) begin
      s_next.hold = 1'b0;
    end
    if (ep0_stall_set) begin
      s_next.ep0_stall = 1'b1;
    end
    if (ep_stall_wr) begin
      s_next.ep_stall[ep_stall_sel] = ep_stall_val;
    end

    // A new control transfer aborts a pending reply after the byte of this cycle; an IN token in the same cycle still starts an armed one.
    if (rx.setup_token) begin
      s_next.irq_req[IRQ_BIT_SETUP_TOKEN] = 1'b1;
      s_next.ep0_stall = 1'b0;
      s_next.hold = 1'b1;
      s_next.in_armed = 1'b0;
      s_next.tx_state = TX_IDLE;
    end

    if (setup_done) begin
      if (is_fw_load) begin
        s_next.load_start = 1'b1;
        s_next.load_dir = req_type[TYPE_DIR_BIT];
        s_next.load_addr = {setup_byte_area[SETUP_OFS_VALUE_H],
                            setup_byte_area[SETUP_OFS_VALUE_L]};
        s_next.load_len = {setup_byte_area[SETUP_OFS_LEN_H],
                           setup_byte_area[SETUP_OFS_LEN_L]};
        s_next.hold = 1'b0;
      end else if (firmware_in_control && is_set_addr) begin
        s_next.fn_addr = setup_byte_area[SETUP_OFS_VALUE_L][6:0];
        s_next.hold = 1'b0;
      end else if (firmware_in_control) begin
        s_next.irq_req[IRQ_BIT_SETUP_DATA] = 1'b1;
      end
    end

    // Endpoint-zero IN data, status stage and bulk handshakes.
    if (tok.in_token) begin
      s_next.hs_valid = 1'b1;
      if (s_reg.ep0_stall) begin
        s_next.hs_code = HS_STALL;
      end else if (s_reg.in_armed && s_reg.tx_state == TX_IDLE) begin
        s_next.hs_code = HS_DATA;
        s_next.in_armed = 1'b0;
        s_next.tx_state = TX_SEND;
        s_next.tx_idx = 6'h00;
        s_next.tx_left = s_reg.in_count;
      end else begin
        s_next.hs_code = HS_NAK;
      end
    end else if (tok.status_token) begin
      s_next.hs_valid = 1'b1;
      if (s_reg.ep0_stall) begin
        s_next.hs_code = HS_STALL;
      end else if (s_reg.hold) begin
        s_next.hs_code = HS_NAK;
      end else begin
        s_next.hs_code = HS_ACK;
      end
    end else if (tok.bulk_token) begin
      s_next.hs_valid = 1'b1;
      if (s_reg.ep_stall[tok.bulk_ep]) begin
        s_next.hs_code = HS_STALL;
      end else begin
        s_next.hs_code = tok.bulk_ready ? HS_ACK : HS_NAK;
      end
    end

    case (s_reg.tx_state)
      TX_IDLE: begin
      end
      TX_SEND: begin
        if (s_reg.tx_left != 7'h00) begin
          s_next.tx_valid = 1'b1;
          s_next.tx_byte = s_reg.in_buf[s_reg.tx_idx];
          s_next.tx_idx = s_reg.tx_idx + 6'h01;
          s_next.tx_left = s_reg.tx_left - 7'h01;
        end else begin
          s_next.tx_state = TX_IDLE;
        end
      end
      default: begin
        s_next.tx_state = TX_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.irq_en <= IRQ_ENABLE_RESET;
      s_reg.irq_req <= IRQ_REQUEST_RESET;
      s_reg.fn_addr <= FN_ADDR_RESET;
      s_reg.tx_state <= TX_IDLE;
      s_reg.hs_code <= HS_ACK;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign hs_valid = s_reg.hs_valid;
  assign hs_code = s_reg.hs_code;
  assign tx_valid = s_reg.tx_valid;
  assign tx_byte = s_reg.tx_byte;
  assign link_irq_enable_reg = s_reg.irq_en;
  assign link_irq_request_reg = s_reg.irq_req;
  assign setup_token_irq_flag = s_reg.irq_req[IRQ_BIT_SETUP_TOKEN];
  assign setup_data_ready_flag = s_reg.irq_req[IRQ_BIT_SETUP_DATA];
  assign function_address_reg = s_reg.fn_addr;
  assign setup_data_pointer = s_reg.sud_ptr;
  assign status_stage_hold = s_reg.hold;
  assign control_endpoint_stall = s_reg.ep0_stall;
  assign bulk_stall = s_reg.ep_stall;
  assign load_start = s_reg.load_start;
  assign load_dir = s_reg.load_dir;
  assign load_addr = s_reg.load_addr;
  assign load_len = s_reg.load_len;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_set_address_update: assert property (
    ce && setup_done && firmware_in_control && is_set_addr && !is_fw_load |=>
    function_address_reg == $past(setup_byte_area[SETUP_OFS_VALUE_L][6:0]) && !status_stage_hold)
    else $error("set address did not update the function address");
  a_setup_data_raise: assert property (
    ce && setup_done && firmware_in_control && !is_set_addr && !is_fw_load |=>
    setup_data_ready_flag)
    else $error("setup data flag not raised for a firmware request");
  a_fw_load_start: assert property (
    ce && setup_done && is_fw_load |=> load_start &&
    load_addr == {$past(setup_byte_area[SETUP_OFS_VALUE_H]),
                  $past(setup_byte_area[SETUP_OFS_VALUE_L])} &&
    (!setup_data_ready_flag || $past(setup_data_ready_flag)))
    else $error("firmware load request not started");
  a_flag_sticky: assert property (
    setup_data_ready_flag && !(ce && irq_clear_wr && irq_clear_data[IRQ_BIT_SETUP_DATA]) |=>
    setup_data_ready_flag)
    else $error("setup data flag dropped without a clear");
  a_status_nak_hold: assert property (
    ce && tok.status_token && !tok.in_token && status_stage_hold && !control_endpoint_stall |=>
    hs_valid && hs_code == HS_NAK)
    else $error("status stage not refused while held");
  a_status_ack_free: assert property (
    ce && tok.status_token && !tok.in_token && !status_stage_hold && !control_endpoint_stall |=>
    hs_valid && hs_code == HS_ACK)
    else $error("status stage not acknowledged after release");
  a_stall_auto_clear: assert property (
    ce && rx.setup_token |=> !control_endpoint_stall ##0 setup_token_irq_flag)
    else $error("setup token did not clear the stall");
  a_bulk_stall_reply: assert property (
    ce && tok.bulk_token && !tok.in_token && !tok.status_token && bulk_stall[tok.bulk_ep] |=>
    hs_valid && hs_code == HS_STALL)
    else $error("stalled bulk endpoint not answered with stall");
  a_in_reply_data: assert property (
    ce && tok.in_token && s_reg.in_armed && !control_endpoint_stall &&
    s_reg.tx_state == TX_IDLE && s_reg.in_count != 7'h00 && !rx.setup_token ##1 ce |->
    hs_code == HS_DATA ##0 (ce ##1 tx_valid && tx_byte == s_reg.in_buf[0]) or !ce)
    else $error("armed IN data not sent on the IN token");

endmodule // control_endpoint_request_handler

`default_nettype wire

// ---- bench/usb_host_model.sv ----
// Host stand-in that sends setup packets and tokens towards endpoint zero and the bulk endpoints.
`timescale 1ns/1ps
`default_nettype none

module usb_host_model
  import ctrl_ep_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus events towards the block
  output var setup_rx_t rx,
  output var token_t tok
);
  initial begin
    rx = '0;
    tok = '0;
  end

  task automatic step;
    @(posedge clk);
    #2;
  endtask

  // A failed check stands for a corrupted packet that the bus would retry.
  task automatic setup(input logic [63:0] b, input logic ok);
    rx.setup_token = 1'b1;
    step;
    rx.setup_token = 1'b0;
    for (int k = 0; k < 8; k++) begin
      rx.byte_valid = 1'b1;
      rx.data = b[8*k +: 8];
      step;
    end
    rx.byte_valid = 1'b0;
    // The released data line is inverted so stale bytes never look valid.
    rx.data = ~rx.data;
    rx.packet_end = 1'b1;
    rx.packet_ok = ok;
    step;
    rx.packet_end = 1'b0;
    rx.packet_ok = ~ok;
  endtask

  // Kind 0 is an IN token, 1 a status handshake and 2 a bulk transaction.
  task automatic token(input int kind, input logic [3:0] ep, input logic rdy);
    tok.in_token = (kind == 0);
    tok.status_token = (kind == 1);
    tok.bulk_token = (kind == 2);
    tok.bulk_ep = ep;
    tok.bulk_ready = rdy;
    step;
    tok.in_token = 1'b0;
    tok.status_token = 1'b0;
    tok.bulk_token = 1'b0;
    tok.bulk_ep = ~ep;
    tok.bulk_ready = ~rdy;
  endtask
endmodule // usb_host_model

`default_nettype wire

// ---- bench/test_control_endpoint_request_handler.sv ----
// Self-checking bench for the endpoint-zero request handler.
`timescale 1ns/1ps
`default_nettype none

module test_control_endpoint_request_handler
  import ctrl_ep_pkg::*;
;
  logic clk, rst, ce, firmware_in_control;
  logic irq_enable_wr, irq_clear_wr, sud_ptr_high_wr, sud_ptr_low_wr, in_buf_wr;
  logic in_count_wr, hold_clear_wr, ep0_stall_set, ep_stall_wr, ep_stall_val;
  logic [7:0] irq_enable_data, irq_clear_data, sud_ptr_data, in_buf_data, tx_byte;
  logic [5:0] in_buf_addr;
  logic [6:0] in_count_data, function_address_reg;
  logic [3:0] ep_stall_sel;
  logic hs_valid, tx_valid, setup_token_irq_flag, setup_data_ready_flag;
  logic status_stage_hold, control_endpoint_stall, load_start, load_dir;
  logic [7:0] link_irq_enable_reg, link_irq_request_reg;
  logic [15:0] setup_data_pointer, load_addr, load_len;
  logic [BULK_SLOTS-1:0] bulk_stall;
  logic [SETUP_BYTES-1:0][7:0] setup_byte_area;
  hs_t hs_code;
  setup_rx_t rx;
  token_t tok;
  logic [63:0] pkt;
  int num_errors = 0;
  int checked = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  usb_host_model HOST (.clk, .rx, .tok);

  control_endpoint_request_handler DUT (
    .clk, .rst, .ce, .rx, .tok, .hs_valid, .hs_code, .tx_valid, .tx_byte,
    .firmware_in_control, .irq_enable_wr, .irq_enable_data, .irq_clear_wr,
    .irq_clear_data, .sud_ptr_high_wr, .sud_ptr_low_wr, .sud_ptr_data, .in_buf_wr,
    .in_buf_addr, .in_buf_data, .in_count_wr, .in_count_data, .hold_clear_wr,
    .ep0_stall_set, .ep_stall_wr, .ep_stall_sel, .ep_stall_val, .link_irq_enable_reg,
    .link_irq_request_reg, .setup_token_irq_flag, .setup_data_ready_flag,
    .function_address_reg, .setup_data_pointer, .setup_byte_area, .status_stage_hold,
    .control_endpoint_stall, .bulk_stall, .load_start, .load_dir, .load_addr, .load_len
  );

  // =====================
  // Access tasks
  // =====================
  task automatic step;
    @(posedge clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Firmware write; the trailing idle edge keeps two strobes of one kind apart.
  task automatic fw(input int op, input logic [7:0] d, input logic [5:0] a);
    {irq_enable_data, irq_clear_data, sud_ptr_data, in_buf_data} = {4{d}};
    in_buf_addr = a;
    in_count_data = d[6:0];
    ep_stall_sel = a[3:0];
    ep_stall_val = d[0];
    case (op)
      0: irq_enable_wr = 1'b1;
      1: irq_clear_wr = 1'b1;
      2: sud_ptr_high_wr = 1'b1;
      3: sud_ptr_low_wr = 1'b1;
      4: in_buf_wr = 1'b1;
      5: in_count_wr = 1'b1;
      6: hold_clear_wr = 1'b1;
      7: ep0_stall_set = 1'b1;
      default: ep_stall_wr = 1'b1;
    endcase
    step;
    {irq_enable_wr, irq_clear_wr, sud_ptr_high_wr, sud_ptr_low_wr, in_buf_wr} = '0;
    {in_count_wr, hold_clear_wr, ep0_stall_set, ep_stall_wr} = '0;
    step;
  endtask

  task automatic tk(input int kind, input logic [3:0] ep, input logic rdy, input hs_t exp);
    int n;
    n = 0;
    HOST.token(kind, ep, rdy);
    while (hs_valid !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    chk("hs_valid", 1'b1, hs_valid);
    if (hs_valid !== 1'b1) begin
      final_report;
    end
    chk("hs_code", exp, hs_code);
    step;
  endtask

  // One edge after the packet end the flags, the address and the one-cycle
  // load pulse all stand, so checks after a packet are made there, save the data flag recheck four edges later.
  task automatic send(input logic [63:0] p, input logic ok);
    HOST.setup(p, ok);
    step;
  endtask

  // =====================
  // Scenarios
  // =====================
  initial begin
    {rst, ce, firmware_in_control} = 3'b110;
    {irq_enable_wr, irq_clear_wr, sud_ptr_high_wr, sud_ptr_low_wr, in_buf_wr} = '0;
    {in_count_wr, hold_clear_wr, ep0_stall_set, ep_stall_wr, ep_stall_val} = '0;
    {irq_enable_data, irq_clear_data, sud_ptr_data, in_buf_data} = '0;
    {in_buf_addr, in_count_data, ep_stall_sel} = '0;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
    chk("request_reg", 8'h00, link_irq_request_reg);
    chk("fn_addr", 7'h00, function_address_reg);
    chk("hs_code", HS_ACK, hs_code);
    firmware_in_control = 1'b1;
    fw(0, 8'h05, 6'h00);
    chk("enable_reg", 8'h05, link_irq_enable_reg);
    fw(2, 8'h12, 6'h00);
    fw(3, 8'h34, 6'h00);
    chk("pointer", 16'h1234, setup_data_pointer);
    pkt = 64'h0002000000000080;
    send(pkt, 1'b1);
    chk("setup_bytes", pkt, setup_byte_area);
    chk("request_reg", 8'h05, link_irq_request_reg);
    chk("length", 16'h0002, {setup_byte_area[7], setup_byte_area[6]});
    chk("hold", 1'b1, status_stage_hold);
    repeat (4) step;
    chk("data_flag", 1'b1, setup_data_ready_flag);
    fw(4, 8'h03, 6'h00);
    fw(4, 8'h00, 6'h01);
    fw(5, 8'h02, 6'h00);
    tk(1, 4'h0, 1'b1, HS_NAK);
    tk(0, 4'h0, 1'b1, HS_DATA);
    chk("tx_byte0", {1'b1, 8'h03}, {tx_valid, tx_byte});
    step;
    chk("tx_byte1", {1'b1, 8'h00}, {tx_valid, tx_byte});
    fw(6, 8'h01, 6'h00);
    tk(1, 4'h0, 1'b1, HS_ACK);
    fw(1, 8'h05, 6'h00);
    chk("request_reg", 8'h00, link_irq_request_reg);
    send(pkt, 1'b0);
    chk("request_reg", 8'h04, link_irq_request_reg);
    chk("token_flag", 1'b1, setup_token_irq_flag);
    // Enables off from here on: the flags must still be readable by polling.
    fw(0, 8'h00, 6'h00);
    // With the clock enable low a firmware write must leave no trace.
    ce = 1'b0;
    fw(0, 8'hFF, 6'h00);
    chk("enable_reg", 8'h00, link_irq_enable_reg);
    ce = 1'b1;
    send(64'h00000000002A0500, 1'b1);
    chk("fn_addr", 7'h2A, function_address_reg);
    chk("hold", 1'b0, status_stage_hold);
    chk("request_reg", 8'h04, link_irq_request_reg);
    fw(1, 8'h04, 6'h00);
    for (int i = 0; i < 2; i++) begin
      firmware_in_control = i[0];
      send({48'h001000001234, 8'hA0, (i == 1) ? 8'hC0 : 8'h40}, 1'b1);
      chk("load_start", 1'b1, load_start);
      chk("load_dir", i[0], load_dir);
      chk("load_addr", 16'h1234, load_addr);
      chk("load_len", 16'h0010, load_len);
      chk("data_flag", 1'b0, setup_data_ready_flag);
      fw(1, 8'h05, 6'h00);
    end
    // A custom vendor code outside the reserved range goes to firmware.
    send(64'h000000000000B140, 1'b1);
    chk("load_start", 1'b0, load_start);
    chk("data_flag", 1'b1, setup_data_ready_flag);
    fw(1, 8'h05, 6'h00);
    pkt = 64'h000000000000A020;
    send(pkt, 1'b1);
    chk("load_start", 1'b0, load_start);
    chk("request_reg", 8'h05, link_irq_request_reg);
    fw(7, 8'h00, 6'h00);
    chk("ep0_stall", 1'b1, control_endpoint_stall);
    tk(1, 4'h0, 1'b1, HS_STALL);
    tk(0, 4'h0, 1'b1, HS_STALL);
    send(pkt, 1'b1);
    chk("ep0_stall", 1'b0, control_endpoint_stall);
    // Index 0x81 names IN endpoint 1, held in slot {direction, number}.
    fw(8, 8'h01, 6'h09);
    chk("bulk_stall", 16'h0200, bulk_stall);
    tk(2, 4'h9, 1'b1, HS_STALL);
    tk(2, 4'h1, 1'b1, HS_ACK);
    tk(2, 4'h1, 1'b0, HS_NAK);
    fw(8, 8'h00, 6'h09);
    tk(2, 4'h9, 1'b1, HS_ACK);
    final_report;
  end
endmodule // test_control_endpoint_request_handler

`default_nettype wire
